// file: origin_return_pkg.sv
package origin_return_pkg;
    // Start numbers written by the host
    localparam logic [15:0] START_MACHINE_RETURN = 16'h2329; // 9001
    localparam logic [15:0] START_FAST_RETURN = 16'h232a; // 9002
    // Status word bit positions
    localparam int STATUS_REQ_BIT = 3;
    localparam int STATUS_DONE_BIT = 4;
    localparam int STATUS_ERR_BIT = 5;
    localparam int STATUS_BUSY_BIT = 6;
    // External signal monitor bit positions
    localparam int EXT_DRIVE_READY_BIT = 2;
    localparam int EXT_DOG_BIT = 0;
    localparam int EXT_ZERO_BIT = 1;
    // Reset values
    localparam logic [15:0] STATUS_RESET = 16'h0008;
    localparam logic [15:0] EXT_RESET = 16'h0000;
    // Timing
    localparam int CLK_HZ = 100_000_000;
    localparam int PULSE_DIV_CYCLES = 100;  // Speed unit tick, 1 us
    localparam int DWELL_UNIT_NS = 1_000_000;  // Dwell is in ms
    localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
    localparam int DWELL_UNIT_CYCLES = DWELL_UNIT_NS / CLK_PERIOD_NS;
    localparam int CLEAR_TIME_US = 10;  // Deviation clear output length
    localparam int CLEAR_CYCLES = CLEAR_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int WIDTH_ADDR = 32;
    localparam int WIDTH_SPEED = 16;
    // Method codes
    typedef enum logic [2:0] {
        METHOD_DOG = 3'h0,
        METHOD_STOP1 = 3'h1,
        METHOD_STOP2 = 3'h2,
        METHOD_STOP3 = 3'h3,
        METHOD_COUNT1 = 3'h4,
        METHOD_COUNT2 = 3'h5
    } method_t;
    // Sequencer states
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_FAST = 4'h1,
        ST_CREEP = 4'h2,
        ST_DOG_OFF = 4'h3,
        ST_DWELL = 4'h4,
        ST_WAIT_ZERO = 4'h5,
        ST_TRAVEL = 4'h6,
        ST_CLEAR = 4'h7,
        ST_LOAD = 4'h8
    } state_t;
endpackage

// file: origin_return_sequencer.sv
`timescale 1ns/1ps
module origin_return_sequencer #(
    parameter int ADDR_W = origin_return_pkg::WIDTH_ADDR,
    parameter int SPEED_W = origin_return_pkg::WIDTH_SPEED,
    parameter int DWELL_UNIT = origin_return_pkg::DWELL_UNIT_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic host_ready_output,
    input wire logic driveReady,
    input wire logic nearDog,
    input wire logic zeroSignal,
    input wire logic startReq,
    input wire logic [15:0] startNumber,
    input wire logic [2:0] return_method_select,
    input wire logic returnDirection,
    input wire logic [SPEED_W-1:0] returnSpeed,
    input wire logic [SPEED_W-1:0] creep_speed_value,
    input wire logic [15:0] return_dwell_time,
    input wire logic [ADDR_W-1:0] post_dog_travel_amount,
    input wire logic [ADDR_W-1:0] origin_address_value,
    output logic [15:0] axis_status_word,
    output logic [15:0] external_signal_monitor,
    output logic [ADDR_W-1:0] current_feed_position,
    output logic [ADDR_W-1:0] machine_feed_position,
    output logic pulseOut,
    output logic pulseDir,
    output logic deviationClear,
    output logic positionValid
);
    localparam int CLR_W = $clog2(origin_return_pkg::CLEAR_CYCLES + 1);
    localparam int DIV_W = $clog2(origin_return_pkg::PULSE_DIV_CYCLES + 1);
    localparam int DW_W = $clog2(DWELL_UNIT + 1);

    // Two-flop synchronisers for the pins
    logic [3:0] syncA_r;
    logic [3:0] syncB_r;
    logic [3:0] syncPrev_r;
    wire logic [3:0] pinRaw = {host_ready_output, driveReady, nearDog,
        zeroSignal};
    always_ff @(posedge sys_clk) begin
        syncA_r <= pinRaw;
        syncB_r <= syncA_r;
        syncPrev_r <= syncB_r;
    end
    wire logic hostRdy = syncB_r[3];
    wire logic drvRdy = syncB_r[2];
    wire logic dog = syncB_r[1];
    wire logic zero = syncB_r[0];
    wire logic hostRise = syncB_r[3] & ~syncPrev_r[3];
    wire logic drvFall = ~syncB_r[2] & syncPrev_r[2];
    wire logic dogRise = syncB_r[1] & ~syncPrev_r[1];
    wire logic dogFall = ~syncB_r[1] & syncPrev_r[1];
    wire logic zeroRise = syncB_r[0] & ~syncPrev_r[0];

    // Start request edge from host logic (same clock)
    logic startPrev_r;
    always_ff @(posedge sys_clk) begin
        startPrev_r <= rst ? 1'b0 : startReq;
    end
    wire logic startEdge = startReq & ~startPrev_r;

    // Fast return is not implemented here; only machine return starts
    wire logic methodOk = return_method_select <= 3'h5;
    wire logic goMachine = startEdge
        && startNumber == origin_return_pkg::START_MACHINE_RETURN;
    wire logic goFast = startEdge
        && startNumber == origin_return_pkg::START_FAST_RETURN;

    origin_return_pkg::state_t state_r, state_nxt;
    origin_return_pkg::method_t method_r;
    logic reqFlag_r, doneFlag_r, errFlag_r;
    logic [SPEED_W-1:0] speed_r, speed_nxt;
    logic [ADDR_W-1:0] travel_r;
    logic [15:0] dwellMs_r;
    logic [DW_W-1:0] dwellSub_r;
    logic [CLR_W-1:0] clrCnt_r;
    logic [DIV_W-1:0] tickCnt_r;
    logic [SPEED_W-1:0] phase_r;
    logic pulse_r, dir_r, clear_r, travelArmed_r;

    // Speed tick divider gives the pulse-rate base
    wire logic tick = tickCnt_r == DIV_W'(origin_return_pkg::PULSE_DIV_CYCLES
        - 1);
    always_ff @(posedge sys_clk) begin
        tickCnt_r <= (rst || tick) ? '0 : tickCnt_r + 1'b1;
    end

    // Phase accumulator: one pulse per wrap, rate set by speed
    wire logic [SPEED_W:0] phaseSum = {1'b0, phase_r} + {1'b0, speed_r};
    wire logic moving = !(state_r inside {origin_return_pkg::ST_IDLE,
        origin_return_pkg::ST_CLEAR, origin_return_pkg::ST_LOAD});
    wire logic emitPulse = moving && tick && phaseSum[SPEED_W];

    // Deceleration steps down toward creep on each tick
    wire logic atCreep = speed_r <= creep_speed_value;
    wire logic decel = state_r != origin_return_pkg::ST_FAST;
    always_comb begin
        speed_nxt = speed_r;
        if (decel && tick && !atCreep) begin
            speed_nxt = speed_r - 1'b1;
        end
    end

    wire logic dwellDone = dwellMs_r == 16'h0000;
    wire logic travelDone = travelArmed_r && travel_r == '0;
    wire logic clrDone = clrCnt_r == '0;
    wire logic zeroWaitMethod = method_r != origin_return_pkg::METHOD_STOP1;

    // Sequencer next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            origin_return_pkg::ST_IDLE: begin
                if (goMachine && methodOk) begin
                    if (return_method_select == 3'h3 || dog) begin
                        state_nxt = origin_return_pkg::ST_CREEP;
                    end else begin
                        state_nxt = origin_return_pkg::ST_FAST;
                    end
                end
            end
            origin_return_pkg::ST_FAST: begin
                if (dogRise) begin
                    state_nxt = origin_return_pkg::ST_CREEP;
                end
            end
            origin_return_pkg::ST_CREEP: begin
                case (method_r)
                    origin_return_pkg::METHOD_DOG: begin
                        if (dogFall && atCreep) begin
                            state_nxt = origin_return_pkg::ST_DOG_OFF;
                        end
                    end
                    origin_return_pkg::METHOD_STOP1: begin
                        if (atCreep) begin
                            state_nxt = origin_return_pkg::ST_DWELL;
                        end
                    end
                    origin_return_pkg::METHOD_COUNT1,
                    origin_return_pkg::METHOD_COUNT2: begin
                        state_nxt = origin_return_pkg::ST_TRAVEL;
                    end
                    default: begin
                        if (zeroRise) begin
                            state_nxt = origin_return_pkg::ST_CLEAR;
                        end
                    end
                endcase
            end
            origin_return_pkg::ST_DOG_OFF: begin
                if (zeroRise) begin
                    state_nxt = origin_return_pkg::ST_CLEAR;
                end
            end
            origin_return_pkg::ST_DWELL: begin
                if (dwellDone) begin
                    state_nxt = origin_return_pkg::ST_CLEAR;
                end
            end
            origin_return_pkg::ST_TRAVEL: begin
                if (travelDone) begin
                    state_nxt = (method_r == origin_return_pkg::METHOD_COUNT2)
                        ? origin_return_pkg::ST_LOAD
                        : origin_return_pkg::ST_WAIT_ZERO;
                end
            end
            origin_return_pkg::ST_WAIT_ZERO: begin
                if (zeroRise && zeroWaitMethod) begin
                    state_nxt = origin_return_pkg::ST_CLEAR;
                end
            end
            origin_return_pkg::ST_CLEAR: begin
                if (clrDone) begin
                    state_nxt = origin_return_pkg::ST_LOAD;
                end
            end
            origin_return_pkg::ST_LOAD: begin
                state_nxt = origin_return_pkg::ST_IDLE;
            end
            default: begin
                state_nxt = origin_return_pkg::ST_IDLE;
            end
        endcase
    end

    // State, speed and method latch
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_r <= origin_return_pkg::ST_IDLE;
            method_r <= origin_return_pkg::METHOD_DOG;
            speed_r <= '0;
            dir_r <= 1'b0;
        end else if (state_r == origin_return_pkg::ST_IDLE) begin
            state_r <= state_nxt;
            method_r <= origin_return_pkg::method_t'(return_method_select);
            dir_r <= returnDirection;
            speed_r <= (return_method_select == 3'h3 || dog)
                ? creep_speed_value : returnSpeed;
        end else begin
            state_r <= state_nxt;
            speed_r <= speed_nxt;
        end
    end

    // Pulse generator; pulse stops when origin is fixed
    always_ff @(posedge sys_clk) begin
        if (rst || !moving) begin
            phase_r <= '0;
            pulse_r <= 1'b0;
        end else begin
            if (tick) begin
                phase_r <= phaseSum[SPEED_W-1:0];
            end
            pulse_r <= emitPulse;
        end
    end

    // Travel amount counted in pulses from the dog rise, or from creep entry when the start is made on the dog
    always_ff @(posedge sys_clk) begin
        if (rst || state_r == origin_return_pkg::ST_IDLE) begin
            travel_r <= post_dog_travel_amount;
            travelArmed_r <= 1'b0;
        end else begin
            if (dogRise || (state_r == origin_return_pkg::ST_CREEP
                && !travelArmed_r)) begin
                travelArmed_r <= 1'b1;
            end
            if (travelArmed_r && emitPulse && travel_r != '0) begin
                travel_r <= travel_r - 1'b1;
            end
        end
    end

    // Dwell timer in millisecond units, started on reaching creep
    always_ff @(posedge sys_clk) begin
        if (rst || state_r != origin_return_pkg::ST_DWELL) begin
            dwellMs_r <= return_dwell_time;
            dwellSub_r <= '0;
        end else if (!dwellDone) begin
            if (dwellSub_r == DW_W'(DWELL_UNIT - 1)) begin
                dwellSub_r <= '0;
                dwellMs_r <= dwellMs_r - 16'h0001;
            end else begin
                dwellSub_r <= dwellSub_r + 1'b1;
            end
        end
    end

    // Deviation counter clear pulse of fixed length
    always_ff @(posedge sys_clk) begin
        if (rst || state_r != origin_return_pkg::ST_CLEAR) begin
            clrCnt_r <= CLR_W'(origin_return_pkg::CLEAR_CYCLES);
            clear_r <= 1'b0;
        end else begin
            clear_r <= !clrDone;
            if (!clrDone) begin
                clrCnt_r <= clrCnt_r - 1'b1;
            end
        end
    end

    // Flags; an event sets and a completion clears, set wins
    wire logic reqSet = drvFall || hostRise;
    wire logic finish = state_r == origin_return_pkg::ST_LOAD;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reqFlag_r <= origin_return_pkg::STATUS_RESET
                [origin_return_pkg::STATUS_REQ_BIT];
            doneFlag_r <= 1'b0;
            errFlag_r <= 1'b0;
        end else begin
            if (reqSet) begin
                reqFlag_r <= 1'b1;
                doneFlag_r <= 1'b0;
            end else if (finish) begin
                reqFlag_r <= 1'b0;
                doneFlag_r <= 1'b1;
            end
            if (goMachine) begin
                errFlag_r <= !methodOk;
            end else if (goFast && !doneFlag_r) begin
                errFlag_r <= 1'b1;
            end
        end
    end

    // Position monitors take the origin address, not stored data
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            current_feed_position <= '0;
            machine_feed_position <= '0;
        end else if (finish) begin
            current_feed_position <= origin_address_value;
            machine_feed_position <= origin_address_value;
        end
    end

    // Registered outputs
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            axis_status_word <= origin_return_pkg::STATUS_RESET;
            external_signal_monitor <= origin_return_pkg::EXT_RESET;
            pulseOut <= 1'b0;
            pulseDir <= 1'b0;
            deviationClear <= 1'b0;
            positionValid <= 1'b0;
        end else begin
            axis_status_word <= 16'h0000;
            axis_status_word[origin_return_pkg::STATUS_REQ_BIT] <= reqFlag_r;
            axis_status_word[origin_return_pkg::STATUS_DONE_BIT] <=
                doneFlag_r;
            axis_status_word[origin_return_pkg::STATUS_ERR_BIT] <= errFlag_r;
            axis_status_word[origin_return_pkg::STATUS_BUSY_BIT] <=
                state_r != origin_return_pkg::ST_IDLE;
            external_signal_monitor <= 16'h0000;
            external_signal_monitor[origin_return_pkg::EXT_DRIVE_READY_BIT]
                <= drvRdy;
            external_signal_monitor[origin_return_pkg::EXT_DOG_BIT] <= dog;
            external_signal_monitor[origin_return_pkg::EXT_ZERO_BIT] <= zero;
            pulseOut <= pulse_r;
            pulseDir <= dir_r;
            deviationClear <= clear_r;
            positionValid <= !reqFlag_r && hostRdy;
        end
    end
endmodule

// file: servo_drive_model.sv
`timescale 1ns/1ps
// Drive with dog cam, index pulse and a hard stopper
module servo_drive_model #(
    parameter int DOG_LO = 4,
    parameter int DOG_HI = 14,
    parameter int REV = 8,
    parameter int STOP_AT = 20
) (
    input wire logic sys_clk,
    input wire logic home,
    input wire logic [1:0] zeroMode,
    input wire logic pulseOut,
    output logic nearDog,
    output logic zeroSignal,
    output int travelSteps
);
    // Stopper blocks travel only when it is fitted (contact mode)
    always_ff @(posedge sys_clk) begin
        if (home) begin
            travelSteps <= 0;
        end else if (pulseOut
            && !(zeroMode == 2'h1 && travelSteps >= STOP_AT)) begin
            travelSteps <= travelSteps + 1;
        end
    end
    // Cam is on only inside its window of travel
    assign nearDog = travelSteps >= DOG_LO && travelSteps < DOG_HI;
    // Index once a revolution, contact sense, or a silent line
    assign zeroSignal = (zeroMode == 2'h0) ?
        (travelSteps % REV == 0 && travelSteps != 0) :
        (zeroMode == 2'h1 && travelSteps >= STOP_AT);
endmodule

// file: origin_return_sequencer_asserts.sv
`timescale 1ns/1ps
// Port checks on the return sequencer
module origin_return_sequencer_asserts #(
    parameter int ADDR_W = 32
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic host_ready_output,
    input wire logic startReq,
    input wire logic [2:0] return_method_select,
    input wire logic [ADDR_W-1:0] origin_address_value,
    input wire logic [15:0] axis_status_word,
    input wire logic [15:0] external_signal_monitor,
    input wire logic [ADDR_W-1:0] current_feed_position,
    input wire logic [ADDR_W-1:0] machine_feed_position,
    input wire logic pulseOut,
    input wire logic deviationClear
);
    logic [15:0] clrLen_r;
    logic [15:0] clrLen_nxt;
    // Clear pulse length so far; a fixed count is promised
    assign clrLen_nxt = deviationClear ? clrLen_r + 16'h0001 : 16'h0000;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            clrLen_r <= 16'h0000;
        end else begin
            clrLen_r <= clrLen_nxt;
        end
    end
    // Completion steps: clear ends, then the done flag follows
    sequence clearEnds;
        $fell(deviationClear);
    endsequence
    sequence doneFollows;
        ##[1:6] axis_status_word[4];
    endsequence
    sequence badStart;
        $rose(startReq) && return_method_select > 3'h5 && !axis_status_word[6];
    endsequence
    AST_DONE_CLEARS_REQ: assert property (
        @(posedge sys_clk) disable iff (rst)
        $rose(axis_status_word[4]) |-> !axis_status_word[3])
        else $error("done rose with return-needed set");
    AST_DONE_AFTER_CLEAR: assert property (
        @(posedge sys_clk) disable iff (rst) clearEnds |-> doneFollows)
        else $error("done flag missing after clear");
    AST_CLEAR_LEN: assert property (
        @(posedge sys_clk) disable iff (rst)
        clearEnds |-> clrLen_r == origin_return_pkg::CLEAR_CYCLES)
        else $error("clear pulse of wrong length");
    AST_CLEAR_STILL: assert property (
        @(posedge sys_clk) disable iff (rst)
        deviationClear |-> !pulseOut && axis_status_word[6])
        else $error("pulses during clear");
    AST_LOAD_ORIGIN: assert property (
        @(posedge sys_clk) disable iff (rst)
        $rose(axis_status_word[4]) |-> ##[0:2]
        (current_feed_position == origin_address_value &&
        machine_feed_position == origin_address_value))
        else $error("positions not loaded with origin");
    AST_REQ_READY_FALL: assert property (
        @(posedge sys_clk) disable iff (rst)
        $fell(external_signal_monitor[2]) |-> ##[0:4] axis_status_word[3])
        else $error("no request after drive ready fall");
    AST_REQ_HOST_RISE: assert property (
        @(posedge sys_clk) disable iff (rst)
        $rose(host_ready_output) |-> ##[1:6] axis_status_word[3])
        else $error("no request after host ready rise");
    AST_BAD_METHOD: assert property (
        @(posedge sys_clk) disable iff (rst) badStart |->
        ##[1:4] (axis_status_word[5] && !axis_status_word[6]))
        else $error("bad method not refused");
endmodule

// file: origin_return_sequencer_bench.sv
`timescale 1ns/1ps
// Bench: each return method run against the drive model
module origin_return_sequencer_bench;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic hostRdy = 1'b1;
    logic drvRdy = 1'b1;
    logic startReq = 1'b0;
    logic dir = 1'b0;
    logic home = 1'b1;
    logic [1:0] zeroMode = 2'h0;
    logic [2:0] method = 3'h0;
    logic [15:0] startNum = origin_return_pkg::START_MACHINE_RETURN;
    logic [31:0] origin = 32'h00000000;
    logic [15:0] stat;
    logic [31:0] curPos;
    logic [31:0] machPos;
    logic [15:0] extMon;
    logic nearDog, zeroSig, pulse, pulseDir, devClr, posValid;
    int steps;
    int num_errors = 0;
    int compares = 0;

    // 100 MHz clock
    always #5 sys_clk = ~sys_clk;

    // Speeds differ by ten units so the slowdown stays short
    origin_return_sequencer #(.DWELL_UNIT(10)) DUT (
        .sys_clk(sys_clk), .rst(rst), .host_ready_output(hostRdy),
        .driveReady(drvRdy), .nearDog(nearDog), .zeroSignal(zeroSig),
        .startReq(startReq), .startNumber(startNum),
        .return_method_select(method), .returnDirection(dir),
        .returnSpeed(16'h800a), .creep_speed_value(16'h8000),
        .return_dwell_time(16'h0190), .post_dog_travel_amount(32'h0000000d),
        .origin_address_value(origin), .axis_status_word(stat),
        .external_signal_monitor(extMon), .current_feed_position(curPos),
        .machine_feed_position(machPos), .pulseOut(pulse),
        .pulseDir(pulseDir), .deviationClear(devClr), .positionValid(posValid));

    servo_drive_model drive (.sys_clk(sys_clk), .home(home),
        .zeroMode(zeroMode), .pulseOut(pulse), .nearDog(nearDog),
        .zeroSignal(zeroSig), .travelSteps(steps));

    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_sim;
        $display("errors=%0d compares=%0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Rewind the drive, then one start edge
    task automatic launch;
        home <= 1'b1;
        @(posedge sys_clk);
        home <= 1'b0;
        startReq <= 1'b1;
        @(posedge sys_clk);
        startReq <= 1'b0;
    endtask

    task automatic scen_reset;
        check_val(stat, origin_return_pkg::STATUS_RESET);
        check_val(extMon, origin_return_pkg::EXT_RESET);
        check_val(posValid, 1'b0);
    endtask

    // Raise the return-needed flag from the drive or the host
    task automatic scen_request(input logic byHost);
        if (byHost) hostRdy <= 1'b0;
        else drvRdy <= 1'b0;
        repeat (6) @(posedge sys_clk);
        check_val(extMon[2], byHost);
        hostRdy <= 1'b1;
        drvRdy <= 1'b1;
        repeat (8) @(posedge sys_clk);
        check_val(stat[4:3], 2'b01);
        check_val(posValid, 1'b0);
    endtask

    // One return, bounded wait, then flags, positions and stop point
    task automatic run_return(input logic [2:0] m, input logic [1:0] zm,
            input logic d, input int expSteps);
        int n;
        logic clrSeen;
        method <= m;
        zeroMode <= zm;
        dir <= d;
        origin <= origin + 32'h01010101;
        launch();
        repeat (3) @(posedge sys_clk);
        check_val(stat[6], 1'b1);
        check_val(pulseDir, d);
        n = 0;
        clrSeen = 1'b0;
        while (stat[6] !== 1'b0 && n < 40000) begin
            @(posedge sys_clk);
            clrSeen = clrSeen | devClr;
            n++;
        end
        if (n >= 40000) begin
            check_val(stat, 16'h0000);
            end_sim();
        end
        repeat (4) @(posedge sys_clk);
        check_val(stat[4:3], 2'b10);
        check_val(posValid, 1'b1);
        check_val(curPos, origin);
        check_val(machPos, origin);
        check_val(steps, expSteps);
        if (m != 3'h5) check_val(clrSeen, 1'b1);
    endtask

    task automatic scen_methods;
        scen_request(1'b0);
        run_return(3'h0, 2'h0, 1'b0, 16);
        scen_request(1'b1);
        run_return(3'h1, 2'h1, 1'b0, 20);
        scen_request(1'b0);
        run_return(3'h2, 2'h1, 1'b0, 20);
        scen_request(1'b1);
        run_return(3'h3, 2'h1, 1'b1, 20);
        scen_request(1'b0);
        run_return(3'h4, 2'h0, 1'b0, 24);
        scen_request(1'b1);
        run_return(3'h5, 2'h2, 1'b0, 17);
    endtask

    // Unknown methods, and fast return with no done flag, are refused
    task automatic scen_refused;
        scen_request(1'b0);
        for (int i = 0; i < 3; i++) begin
            method <= 3'(5 + i);
            startNum <= (i == 0) ? origin_return_pkg::START_FAST_RETURN :
                origin_return_pkg::START_MACHINE_RETURN;
            launch();
            repeat (20) @(posedge sys_clk);
            check_val(stat[6:5], 2'b01);
            check_val(steps, 0);
        end
    endtask

    // Main sequence after a 12-cycle reset
    initial begin
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        home <= 1'b0;
        @(posedge sys_clk);
        scen_reset();
        scen_methods();
        scen_refused();
        end_sim();
    end
endmodule

// Port checker on every sequencer instance
bind origin_return_sequencer origin_return_sequencer_asserts #(
    .ADDR_W(ADDR_W)) chk (.sys_clk(sys_clk), .rst(rst),
    .host_ready_output(host_ready_output), .startReq(startReq),
    .return_method_select(return_method_select),
    .origin_address_value(origin_address_value),
    .axis_status_word(axis_status_word),
    .external_signal_monitor(external_signal_monitor),
    .current_feed_position(current_feed_position),
    .machine_feed_position(machine_feed_position),
    .pulseOut(pulseOut), .deviationClear(deviationClear));
